// File: design/acp_map.svh
// Constants for the configuration serial port: register offsets, reset values,
// instruction fields, host command registers and link timing.
// Assumes a 50 MHz system clock on both ends of the link.
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// Device register offsets (13-bit serial address)
`define ACP_ADDR_PORT_CFG 13'h0000
`define ACP_ADDR_CHIP_ID 13'h0001
`define ACP_ADDR_GRADE 13'h0002
`define ACP_ADDR_CHAN_IDX 13'h0005
`define ACP_ADDR_OFFSET 13'h0010
`define ACP_ADDR_REF_SEL 13'h0018
`define ACP_ADDR_TRANSFER 13'h00ff

// Device reset values
`define ACP_RST_PORT_CFG 8'h18
`define ACP_RST_CHAN_IDX 2'h3
`define ACP_RST_OFFSET 8'h00
`define ACP_RST_REF_SEL 8'hc0

// Port configuration fields, mirrored nibbles
`define ACP_CFG_LSB_HI 6
`define ACP_CFG_LSB_LO 1
`define ACP_CFG_SRST_HI 5
`define ACP_CFG_SRST_LO 2
`define ACP_XFER_BIT 0

// Instruction fields
`define ACP_INSTR_BITS 16
`define ACP_INSTR_RW 15
`define ACP_INSTR_LEN_HI 14
`define ACP_INSTR_LEN_LO 13
`define ACP_LEN_STREAM 2'h3

// Host command registers (Avalon byte addresses)
`define ACP_AVS_CMD 5'h00
`define ACP_AVS_WDATA 5'h04
`define ACP_AVS_RDATA 5'h08
`define ACP_AVS_STATUS 5'h0c
`define ACP_AVS_CFG 5'h10

// Link timing
`define ACP_CLK_NS 20
`define ACP_SCLK_HALF_NS 160
`define ACP_SCLK_HALF_CYC ((`ACP_SCLK_HALF_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_STALL_NS 400
`define ACP_STALL_CYC ((`ACP_STALL_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_STRAP_SETTLE 2'h3

`endif

// File: design/acp_pkg.sv
// Types shared by both ends of the configuration serial port.
// Assumes acp_map.svh supplies the numeric constants.
package acp_pkg;

   typedef enum logic [1:0] {
      ACP_DEV_IDLE  = 2'b00,
      ACP_DEV_INSTR = 2'b01,
      ACP_DEV_DATA  = 2'b10,
      ACP_DEV_DONE  = 2'b11
   } acp_dev_state_t;

   typedef enum logic [1:0] {
      ACP_HOST_IDLE  = 2'b00,
      ACP_HOST_RUN   = 2'b01,
      ACP_HOST_STALL = 2'b10,
      ACP_HOST_END   = 2'b11
   } acp_host_state_t;

endpackage

// File: design/acp_link_if.sv
// Three-wire link between the serial master and the configuration port.
// Assumes the bench joins the ends; the shared data wire is resolved here.
`timescale 1ns/1ps
interface acp_link_if;
   logic sclk;
   logic port_select_n;
   logic host_sdio_out;
   logic host_sdio_oe_n;
   logic dev_sdio_out;
   logic dev_sdio_oe_n;
   logic sdio;

   // Pull-up level when neither end drives the data wire
   assign sdio = !host_sdio_oe_n ? host_sdio_out : (!dev_sdio_oe_n ? dev_sdio_out : 1'b1);

   modport host(output sclk, output port_select_n, output host_sdio_out,
                output host_sdio_oe_n, input sdio);
   modport device(input sclk, input port_select_n, input sdio,
                  output dev_sdio_out, output dev_sdio_oe_n);
endinterface

// File: design/acp_dev.sv
// Configuration serial port of a dual-channel converter: link slave and registers.
// Functional notes
// [R1] Frame starts at select low then clock rise
// [R2] Select held low streams bytes indefinitely
// [R3] Select high between bytes stalls, same frame resumes
// [R4] Select tied high leaves pins undriven
// [R5] Sixteen-bit instruction precedes data
// [R6] Data in whole bytes, count from length bits
// [R7] First instruction bit selects read or write
// [R8] Read turns data pin to output after instruction
// [R9] Bit order MSB first, LSB via configuration
// [R10] Clock and select are inputs only
// [R11] Master keeps port quiet during sampling
// [R12] Unused port: four pins read as straps
// [R13] Stabiliser and format straps, documented defaults
// [R14] Output-enable and power-down straps, low normal
// [R15] Register space in four address regions
// [R16] Master writes zeros to open bits
// [R17] Unmapped locations ignored, read as zero
// [R18] Reset loads documented default values
// [R19] Reference select resets to top two bits
// [R20] Shadowed setup registers apply on transfer bit
// [R21] Channel index steers local registers
// [R22] Sample on rising clock, drive after falling
// [R23] Select rise ends frame, next restarts instruction
// Assumes link pins arrive asynchronously; strap pins are static after power-up.
`timescale 1ns/1ps
`include "acp_map.svh"
module acp_dev #(
   parameter logic [7:0] CHIP_ID = 8'h5a, // Arbitrary identification value
   parameter logic [7:0] GRADE = 8'h00
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   acp_link_if.device link,
   input wire logic i_output_enable_n_strap,
   input wire logic i_power_down_strap,
   output logic o_strap_mode,
   output logic o_dcs_enable,
   output logic o_twos_complement,
   output logic o_outputs_hiz,
   output logic o_power_down,
   output logic [7:0] o_reference_select,
   output logic [15:0] o_channel_offset
);

   // Pin order: {power-down, output-enable, sdio, select, sclk}
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic sclk_prev;
   logic csb_prev;
   logic sclk_rise;
   logic sclk_fall;
   logic csb_low;
   logic csb_rise;
   logic sdi;

   acp_pkg::acp_dev_state_t state;
   logic [3:0] bit_cnt;
   logic [15:0] instr;
   logic [15:0] next_instr;
   logic [7:0] wr_byte;
   logic [7:0] next_byte;
   logic is_read;
   logic [1:0] len;
   logic [1:0] bytes_left;
   logic [12:0] addr;
   logic [3:0] ins_pos;
   logic [2:0] dat_pos;
   logic byte_end;
   logic wr_stb;
   logic soft_rst;
   logic xfer;
   logic [7:0] rd_byte;

   logic lsb_first;
   logic [1:0] chan_idx;
   logic [7:0] ref_shadow;
   logic [7:0] ref_active;
   logic [7:0] off_shadow [2];
   logic [7:0] off_active [2];
   logic [1:0] settle;

   // Two-stage synchroniser; clock and select are only ever sampled here [R10]
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_meta <= 5'h02;
         pin_sync <= 5'h02;
         sclk_prev <= 1'b0;
         csb_prev <= 1'b1;
      end else begin
         pin_meta <= {i_power_down_strap, i_output_enable_n_strap, link.sdio,
                      link.port_select_n, link.sclk};
         pin_sync <= pin_meta;
         sclk_prev <= pin_sync[0];
         csb_prev <= pin_sync[1];
      end
   end

   // Edge events, all taken from the second stage
   assign sclk_rise = pin_sync[0] & ~sclk_prev;
   assign sclk_fall = ~pin_sync[0] & sclk_prev;
   assign csb_low = ~pin_sync[1];
   assign csb_rise = pin_sync[1] & ~csb_prev;
   assign sdi = pin_sync[2];

   // Bit position within the current field follows the bit order [R9]
   assign ins_pos = lsb_first ? bit_cnt : 4'hf - bit_cnt;
   assign dat_pos = lsb_first ? bit_cnt[2:0] : 3'h7 - bit_cnt[2:0];

   // Incoming bit merged into the field under assembly
   always_comb begin
      next_instr = instr;
      next_instr[ins_pos] = sdi;
      next_byte = wr_byte;
      next_byte[dat_pos] = sdi;
   end

   assign byte_end = sclk_rise && csb_low && state == acp_pkg::ACP_DEV_DATA && bit_cnt == 4'h7;
   assign wr_stb = byte_end && !is_read;
   assign soft_rst = wr_stb && addr == `ACP_ADDR_PORT_CFG &&
                     (next_byte[`ACP_CFG_SRST_HI] || next_byte[`ACP_CFG_SRST_LO]);
   assign xfer = wr_stb && addr == `ACP_ADDR_TRANSFER && next_byte[`ACP_XFER_BIT]; // [R20]

   // Frame sequencer: instruction, then whole data bytes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= acp_pkg::ACP_DEV_IDLE;
         bit_cnt <= 4'h0;
         instr <= 16'h0000;
         wr_byte <= 8'h00;
         is_read <= 1'b0;
         len <= 2'h0;
         bytes_left <= 2'h0;
         addr <= 13'h0000;
      end else if (csb_rise) begin
         // Rise at a byte boundary with bytes owed is a stall, else end of frame
         if (!(state == acp_pkg::ACP_DEV_DATA && bit_cnt == 4'h0 &&
               len != `ACP_LEN_STREAM)) begin // [R3]
            state <= acp_pkg::ACP_DEV_IDLE; // [R23]
            bit_cnt <= 4'h0;
         end
      end else if (sclk_rise && csb_low) begin // [R1] [R22]
         case (state)
            acp_pkg::ACP_DEV_IDLE, acp_pkg::ACP_DEV_INSTR: begin
               instr <= next_instr;
               if (bit_cnt == 4'hf) begin // [R5]
                  is_read <= next_instr[`ACP_INSTR_RW]; // [R7]
                  len <= next_instr[`ACP_INSTR_LEN_HI:`ACP_INSTR_LEN_LO];
                  bytes_left <= next_instr[`ACP_INSTR_LEN_HI:`ACP_INSTR_LEN_LO]; // [R6]
                  addr <= next_instr[12:0];
                  bit_cnt <= 4'h0;
                  state <= acp_pkg::ACP_DEV_DATA;
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
                  state <= acp_pkg::ACP_DEV_INSTR;
               end
            end
            acp_pkg::ACP_DEV_DATA: begin
               wr_byte <= next_byte;
               if (bit_cnt == 4'h7) begin
                  bit_cnt <= 4'h0;
                  // Address walks down in MSB-first order, up in LSB-first order
                  addr <= lsb_first ? addr + 13'h0001 : addr - 13'h0001;
                  if (len != `ACP_LEN_STREAM) begin // [R2]
                     if (bytes_left == 2'h0) begin
                        state <= acp_pkg::ACP_DEV_DONE;
                     end else begin
                        bytes_left <= bytes_left - 2'h1;
                     end
                  end
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            default: begin
               bit_cnt <= bit_cnt;
            end
         endcase
      end
   end

   // Read data driven after the falling edge so the master takes it at the end of the high phase
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         link.dev_sdio_out <= 1'b0;
         link.dev_sdio_oe_n <= 1'b1;
      end else if (!csb_low || o_strap_mode) begin
         link.dev_sdio_oe_n <= 1'b1; // [R4]
      end else if (sclk_fall || csb_prev) begin
         // A resumed stall has no clock fall before its first rise, so the
         // fall of select launches the first bit of the next byte [R3]
         if (state == acp_pkg::ACP_DEV_DATA && is_read) begin
            link.dev_sdio_out <= rd_byte[dat_pos]; // [R8] [R22]
            link.dev_sdio_oe_n <= 1'b0;
         end else begin
            link.dev_sdio_oe_n <= 1'b1;
         end
      end
   end

   // Readback mux; anything unmapped reads as zero
   always_comb begin
      case (addr)
         `ACP_ADDR_PORT_CFG: rd_byte = {1'b0, lsb_first, 2'b01, 2'b10, lsb_first, 1'b0};
         `ACP_ADDR_CHIP_ID: rd_byte = CHIP_ID;
         `ACP_ADDR_GRADE: rd_byte = GRADE;
         `ACP_ADDR_CHAN_IDX: rd_byte = {6'h00, chan_idx};
         `ACP_ADDR_REF_SEL: rd_byte = ref_shadow;
         // Both channels selected returns channel A
         `ACP_ADDR_OFFSET: rd_byte = chan_idx[0] ? off_shadow[0] : off_shadow[1]; // [R21]
         default: rd_byte = 8'h00; // [R15] [R17]
      endcase
   end

   // Global registers; soft reset reloads the defaults and clears itself
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lsb_first <= 1'b0; // [R18]
         chan_idx <= `ACP_RST_CHAN_IDX;
         ref_shadow <= `ACP_RST_REF_SEL; // [R19]
         ref_active <= `ACP_RST_REF_SEL;
      end else if (soft_rst) begin
         lsb_first <= 1'b0;
         chan_idx <= `ACP_RST_CHAN_IDX;
         ref_shadow <= `ACP_RST_REF_SEL;
         ref_active <= `ACP_RST_REF_SEL;
      end else if (wr_stb) begin
         case (addr)
            `ACP_ADDR_PORT_CFG:
               lsb_first <= next_byte[`ACP_CFG_LSB_HI] | next_byte[`ACP_CFG_LSB_LO]; // [R9]
            `ACP_ADDR_CHAN_IDX: chan_idx <= next_byte[1:0];
            `ACP_ADDR_REF_SEL: ref_shadow <= next_byte;
            `ACP_ADDR_TRANSFER: begin
               if (xfer) begin
                  ref_active <= ref_shadow; // [R20]
               end
            end
            default: begin
               lsb_first <= lsb_first; // [R17]
            end
         endcase
      end
   end

   // Per-channel local register, shadowed like the rest of the setup range
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_ff @(posedge i_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            off_shadow[ch] <= `ACP_RST_OFFSET;
            off_active[ch] <= `ACP_RST_OFFSET;
         end else if (soft_rst) begin
            off_shadow[ch] <= `ACP_RST_OFFSET;
            off_active[ch] <= `ACP_RST_OFFSET;
         end else begin
            if (wr_stb && addr == `ACP_ADDR_OFFSET && chan_idx[ch]) begin
               off_shadow[ch] <= next_byte; // [R21]
            end
            if (xfer) begin
               off_active[ch] <= off_shadow[ch]; // [R20]
            end
         end
      end
   end

   // Applied settings leave through output flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_reference_select <= `ACP_RST_REF_SEL;
         o_channel_offset <= {`ACP_RST_OFFSET, `ACP_RST_OFFSET};
      end else begin
         o_reference_select <= ref_active;
         o_channel_offset <= {off_active[1], off_active[0]};
      end
   end

   // Strap mode holds until select is first seen low; straps are caught once,
   // after the synchroniser has filled, so a later toggle cannot change them
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         settle <= 2'h0;
         o_strap_mode <= 1'b1;
         o_dcs_enable <= 1'b1; // [R13]
         o_twos_complement <= 1'b0;
         o_outputs_hiz <= 1'b0; // [R14]
         o_power_down <= 1'b0;
      end else begin
         if (settle != `ACP_STRAP_SETTLE) begin
            settle <= settle + 2'h1;
         end
         if (csb_low) begin
            o_strap_mode <= 1'b0;
         end
         if (o_strap_mode && !csb_low && settle == `ACP_STRAP_SETTLE - 2'h1) begin // [R12]
            o_dcs_enable <= pin_sync[2]; // [R13]
            o_twos_complement <= pin_sync[0];
            o_outputs_hiz <= pin_sync[3]; // [R14]
            o_power_down <= pin_sync[4];
         end
      end
   end

endmodule

// File: design/acp_host.sv
// Serial master for the configuration port, ordered over an Avalon-MM slave.
// Assumes one command at a time; the link clock is divided from i_clk.
`timescale 1ns/1ps
`include "acp_map.svh"
module acp_host (
   input wire logic i_clk,
   input wire logic i_arst_n,
   acp_link_if.host link,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);

   localparam logic [4:0] HALF = 5'(`ACP_SCLK_HALF_CYC);
   localparam logic [4:0] STALL = 5'(`ACP_STALL_CYC);

   acp_pkg::acp_host_state_t state;
   logic sdi_meta;
   logic sdi_sync;
   logic [15:0] cmd;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic lsb_first;
   logic stall_en;
   logic done;
   logic [4:0] div;
   logic [5:0] idx;
   logic [5:0] nbits;
   logic [5:0] didx;
   logic [4:0] dpos;
   logic tx_bit;
   logic acc;
   logic start;
   logic finish;

   assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
   assign start = acc && i_avs_write && i_avs_address == `ACP_AVS_CMD &&
                  state == acp_pkg::ACP_HOST_IDLE;
   assign finish = state == acp_pkg::ACP_HOST_END && div == HALF + HALF - 5'h1;

   // Bit placement in the current field follows the configured order
   assign didx = idx - 6'd16;
   assign dpos = {didx[4:3], lsb_first ? didx[2:0] : 3'h7 - didx[2:0]};
   assign tx_bit = idx < 6'd16 ? cmd[lsb_first ? idx[3:0] : 4'hf - idx[3:0]] : wdata[dpos];

   // Data wire comes from outside the clock's domain
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sdi_meta <= 1'b1;
         sdi_sync <= 1'b1;
      end else begin
         sdi_meta <= link.sdio;
         sdi_sync <= sdi_meta;
      end
   end

   // Avalon answer: one wait cycle, then the access completes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else begin
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
         if (i_avs_read && o_avs_waitrequest) begin
            case (i_avs_address)
               `ACP_AVS_CMD: o_avs_readdata <= {16'h0000, cmd};
               `ACP_AVS_WDATA: o_avs_readdata <= wdata;
               `ACP_AVS_RDATA: o_avs_readdata <= rdata;
               `ACP_AVS_STATUS:
                  o_avs_readdata <= {30'h00000000, done, state != acp_pkg::ACP_HOST_IDLE};
               `ACP_AVS_CFG: o_avs_readdata <= {30'h00000000, stall_en, lsb_first};
               default: o_avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Software settings; they are locked while a frame runs
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd <= 16'h0000;
         wdata <= 32'h00000000;
         lsb_first <= 1'b0;
         stall_en <= 1'b0;
         done <= 1'b0;
      end else begin
         if (start) begin
            cmd <= i_avs_writedata[15:0];
         end
         if (acc && i_avs_write && state == acp_pkg::ACP_HOST_IDLE) begin
            if (i_avs_address == `ACP_AVS_WDATA) begin
               wdata <= i_avs_writedata;
            end
            if (i_avs_address == `ACP_AVS_CFG) begin
               lsb_first <= i_avs_writedata[0]; // [R9]
               stall_en <= i_avs_writedata[1];
            end
         end
         // A finishing frame wins over the clear from a new command
         if (finish) begin
            done <= 1'b1;
         end else if (start) begin
            done <= 1'b0;
         end
      end
   end

   // Frame engine: clock divider, shifter and select
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= acp_pkg::ACP_HOST_IDLE;
         link.sclk <= 1'b0;
         link.port_select_n <= 1'b1;
         link.host_sdio_out <= 1'b0;
         link.host_sdio_oe_n <= 1'b1;
         rdata <= 32'h00000000;
         div <= 5'h00;
         idx <= 6'h00;
         nbits <= 6'h00;
      end else begin
         case (state)
            acp_pkg::ACP_HOST_IDLE: begin
               if (start) begin
                  link.port_select_n <= 1'b0; // [R1]
                  div <= 5'h00;
                  idx <= 6'h00;
                  // Streaming code sends four bytes, then the frame is closed
                  nbits <= 6'd16 + {1'b0, i_avs_writedata[14:13] + 2'h1, 3'h0}; // [R5] [R6]
                  if (i_avs_writedata[14:13] == `ACP_LEN_STREAM) begin
                     nbits <= 6'd48;
                  end
                  state <= acp_pkg::ACP_HOST_RUN;
               end
            end
            acp_pkg::ACP_HOST_RUN: begin
               div <= div + 5'h01;
               if (div == 5'h00) begin
                  link.sclk <= 1'b0;
                  link.host_sdio_out <= tx_bit;
                  // Hand the wire to the device once a read instruction is out
                  link.host_sdio_oe_n <= idx >= 6'd16 && cmd[`ACP_INSTR_RW]; // [R7] [R8]
               end else if (div == HALF) begin
                  link.sclk <= 1'b1; // [R22]
               end else if (div == HALF + HALF - 5'h1) begin
                  div <= 5'h00;
                  if (idx >= 6'd16 && cmd[`ACP_INSTR_RW]) begin
                     rdata[dpos] <= sdi_sync;
                  end
                  idx <= idx + 6'h01;
                  if (idx == nbits - 6'h01) begin
                     state <= acp_pkg::ACP_HOST_END;
                  end else if (stall_en && idx >= 6'd16 && idx[2:0] == 3'h7) begin
                     // Select is raised in the stall, on the same edge that brings the clock down
                     state <= acp_pkg::ACP_HOST_STALL;
                  end
               end
            end
            acp_pkg::ACP_HOST_STALL: begin
               link.sclk <= 1'b0;
               div <= div + 5'h01;
               // Select rises with the clock's fall, never while the clock is high
               if (div == 5'h00) begin
                  link.port_select_n <= 1'b1; // [R3]
               end
               if (div == STALL) begin
                  div <= 5'h00;
                  link.port_select_n <= 1'b0;
                  state <= acp_pkg::ACP_HOST_RUN;
               end
            end
            default: begin
               // Closing: clock low, select raised for at least half a period [R23]
               link.sclk <= 1'b0;
               div <= div + 5'h01;
               if (div == HALF) begin
                  link.port_select_n <= 1'b1;
                  link.host_sdio_oe_n <= 1'b1;
               end
               if (finish) begin
                  div <= 5'h00;
                  state <= acp_pkg::ACP_HOST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

// File: testbench/acp_link_monitor.sv
// Checker for the three-wire link joining the host and device ends.
// Assumes tb_top wires the interface signals in by name; one clock domain.
`timescale 1ns/1ps
module acp_link_monitor (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic sclk,
   input wire logic port_select_n,
   input wire logic host_sdio_out,
   input wire logic host_sdio_oe_n,
   input wire logic dev_sdio_out,
   input wire logic dev_sdio_oe_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Link protocol properties
   property p_one_drv; !(!host_sdio_oe_n && !dev_sdio_oe_n); endproperty
   property p_idle_hiz; port_select_n [*8] |-> dev_sdio_oe_n; endproperty
   property p_start; $fell(port_select_n) |-> !sclk ##[1:20] $rose(sclk); endproperty
   property p_end; $rose(port_select_n) |-> !sclk; endproperty
   property p_high; $rose(sclk) |=> sclk [*7] ##1 !sclk; endproperty
   property p_low; $fell(sclk) |=> !sclk [*7]; endproperty
   property p_sel_hold; $rose(port_select_n) |=> port_select_n [*7]; endproperty
   property p_quiet; port_select_n |-> !sclk; endproperty
   property p_host_stable;
      sclk && $past(sclk) && !host_sdio_oe_n |-> $stable(host_sdio_out);
   endproperty
   property p_dev_stable;
      sclk && $past(sclk) && !dev_sdio_oe_n && $past(!dev_sdio_oe_n) |-> $stable(dev_sdio_out);
   endproperty
   a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
   a_idle_hiz: assert property (p_idle_hiz) else $error("device drives unselected");
   a_start: assert property (p_start) else $error("no clock after select");
   a_end: assert property (p_end) else $error("select rose with clock high");
   a_high: assert property (p_high) else $error("clock high phase wrong");
   a_low: assert property (p_low) else $error("clock low phase short");
   a_sel_hold: assert property (p_sel_hold) else $error("select high too short");
   a_quiet: assert property (p_quiet) else $error("clock moved while deselected");
   a_host_stable: assert property (p_host_stable) else $error("host data moved");
   a_dev_stable: assert property (p_dev_stable) else $error("device data moved");
   // Reads, frames and bits seen
   c_read: cover property ($fell(dev_sdio_oe_n));
   c_frame: cover property ($fell(port_select_n));
   c_bit: cover property ($rose(sclk));
endmodule

// File: testbench/tb_top.sv
// Bench joining host and device ends; software side driven over Avalon-MM.
// Assumes design/ files and acp_map.svh on the include path.
`timescale 1ns/1ps
`include "acp_map.svh"
module tb_top;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic oe_strap = 1'b1; // Straps are static from power-up
   logic pd_strap = 1'b0;
   logic [31:0] rdata, q;
   logic wait_req, smode, duty_cycle_stabilizer_strap, twos, hiz, pdn;
   logic [7:0] ref_sel;
   logic [15:0] ofs;
   logic [7:0] rnd = 8'h55;
   logic [7:0] prev = 8'hc0;
   int bad_count = 0;
   int checks_done = 0;
   acp_link_if lk();
   acp_host i_acp_host(.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lk), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_req));
   acp_dev i_acp_dev(.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lk),
      .i_output_enable_n_strap(oe_strap), .i_power_down_strap(pd_strap), .o_strap_mode(smode),
      .o_dcs_enable(duty_cycle_stabilizer_strap), .o_twos_complement(twos), .o_outputs_hiz(hiz), .o_power_down(pdn),
      .o_reference_select(ref_sel), .o_channel_offset(ofs));
   acp_link_monitor i_acp_link_monitor(.i_clk(i_clk), .i_arst_n(i_arst_n), .sclk(lk.sclk),
      .port_select_n(lk.port_select_n), .host_sdio_out(lk.host_sdio_out),
      .host_sdio_oe_n(lk.host_sdio_oe_n), .dev_sdio_out(lk.dev_sdio_out),
      .dev_sdio_oe_n(lk.dev_sdio_oe_n));
   initial forever #10 i_clk = ~i_clk;
   // Random bytes; a fixed seed keeps runs repeatable
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [31:0] cmd(input logic r, input logic [1:0] n, input logic [12:0] a);
      return {16'h0, r, n, a};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low
   task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge i_clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge i_clk); while (wait_req !== 1'b0);
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Start a frame, poll busy, then fetch the received bytes
   task automatic run(input logic [31:0] c);
      av(`ACP_AVS_CMD, 1'b1, c, q);
      do av(`ACP_AVS_STATUS, 1'b0, 32'h0, q); while (q[0] !== 1'b0);
      av(`ACP_AVS_RDATA, 1'b0, 32'h0, q);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      chk("ref reset", 32'hc0, 32'(ref_sel));
      i_arst_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk("strap mode", 32'h1, 32'(smode));
      chk("straps", {28'h0, 1'b1, 1'b0, oe_strap, pd_strap}, {28'h0, duty_cycle_stabilizer_strap, twos, hiz, pdn});
      av(5'h14, 1'b0, 32'h0, q);
      chk("avs unmapped", 32'h0, q);
      // Shadowed write, transfer, then a two-byte read into open space
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         av(`ACP_AVS_WDATA, 1'b1, {24'h0, rnd}, q);
         run(cmd(1'b0, 2'h0, `ACP_ADDR_REF_SEL));
         chk("shadow", 32'(prev), 32'(ref_sel));
         av(`ACP_AVS_WDATA, 1'b1, {24'h0, ~rnd}, q);
         run(cmd(1'b0, 2'h0, `ACP_ADDR_OFFSET));
         av(`ACP_AVS_WDATA, 1'b1, 32'h1, q);
         run(cmd(1'b0, 2'h0, `ACP_ADDR_TRANSFER));
         chk("applied", 32'(rnd), 32'(ref_sel));
         chk("offset", {16'h0, ~rnd, ~rnd}, 32'(ofs));
         run(cmd(1'b1, 2'h1, `ACP_ADDR_REF_SEL));
         chk("readback", {24'h0, rnd}, {16'h0, q[15:0]});
         prev = rnd;
      end
      chk("serial mode", 32'h0, 32'(smode));
      run(cmd(1'b1, 2'h0, `ACP_ADDR_TRANSFER));
      chk("transfer clears", 32'h0, {24'h0, q[7:0]});
      // Stalled write and read between bytes
      av(`ACP_AVS_CFG, 1'b1, 32'h2, q);
      rnd = lfsr(rnd);
      av(`ACP_AVS_WDATA, 1'b1, {16'h0, 8'h00, rnd}, q);
      run(cmd(1'b0, 2'h1, `ACP_ADDR_REF_SEL));
      run(cmd(1'b1, 2'h2, `ACP_ADDR_REF_SEL));
      chk("stall read", {24'h0, rnd}, {8'h0, q[23:0]});
      // Mirrored config value selects LSB first; then a streaming read upward
      av(`ACP_AVS_CFG, 1'b1, 32'h0, q);
      av(`ACP_AVS_WDATA, 1'b1, 32'h5a, q);
      run(cmd(1'b0, 2'h0, `ACP_ADDR_PORT_CFG));
      av(`ACP_AVS_CFG, 1'b1, 32'h1, q);
      run(cmd(1'b1, `ACP_LEN_STREAM, `ACP_ADDR_REF_SEL));
      chk("lsb stream", {24'h0, rnd}, q);
      finish_test();
   end
   // Hang guard, far beyond the expected run length
   initial begin
      #1000000;
      bad_count++;
      finish_test();
   end
endmodule
